// [core/can_msg_ctrl_map.vh]
// Function
// - Length code 0 to 8 means a data frame of that many bytes.
// - Length codes 9 to 15 all mean a data frame of eight bytes.
// - Storing a received data frame overwrites the object length code with the frame's.
// - End-of-buffer at 0 marks a FIFO member that is not the last.
// - End-of-buffer at 1 marks a single object or the last FIFO member.
// - Transmit request at 1 means transmission pending; at 0 nothing waits.
// - Remote enable at 1: a matching remote frame sets transmit request of a transmit-direction object.
// - Remote enable at 0: a matching remote frame leaves transmit request alone.
// - Receive interrupt enable at 1 sets irq pending after a successful reception.
// - Transmit interrupt enable at 1 sets irq pending after a successful transmission.
// - Use-mask at 1 applies identifier and direction masks; at 0 masks are ignored.
// - Irq pending at 1 makes the object reported unless a higher source pends.
// - Irq pending at 0 means the object is never reported.
// - Objects whose valid bit is 0 are ignored on reception and transmission.
// - Remote-triggered transmit request only for transmit-direction objects with remote enable.
`ifndef CAN_MSG_CTRL_MAP_VH
`define CAN_MSG_CTRL_MAP_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define A_CTRL_IF1 32'h40050038
`define A_CTRL_IF2 32'h40050098
`define A_CMD_IF1 32'h40050020
`define A_CMD_IF2 32'h40050080
`define A_MASK_IF1 32'h40050028
`define A_MASK_IF2 32'h40050088
`define A_ARB_IF1 32'h40050030
`define A_ARB_IF2 32'h40050090
`define A_STATUS 32'h40050140
`define A_IRQMASK 32'h40050144
`define A_IRQID 32'h40050148

// ----------------------------------------
// Control word fields
// ----------------------------------------
`define LEN_HI 3
`define LEN_LO 0
`define EOB_BIT 7
`define TXRQ_BIT 8
`define RMT_BIT 9
`define RECEIVE_IRQ_ENABLE_BIT 10
`define TRANSMIT_IRQ_ENABLE_BIT 11
`define USE_MASK_BIT 12
`define IPND_BIT 13
`define CTRL_WMASK 16'h3f8f
`define CTRL_RST 16'h0000

// ----------------------------------------
// Arbitration, mask and command fields
// ----------------------------------------
`define ID_HI 10
`define ARB_DIR_BIT 13
`define ARB_VAL_BIT 15
`define MSK_DIR_BIT 14
`define CMD_WR_BIT 7

// ----------------------------------------
// Status bits and lengths
// ----------------------------------------
`define ST_RX 0
`define ST_TX 1
`define ST_RMT 2
`define ST_W 3
`define MAX_BYTES 4'h8

// ----------------------------------------
// Handler event kinds
// ----------------------------------------
`define EV_RXDATA 2'h0
`define EV_RXRMT 2'h1
`define EV_TXDONE 2'h2

// ----------------------------------------
// Object memory word layout
// ----------------------------------------
`define W_LEN_HI 3
`define W_LEN_LO 0
`define W_EOB 4
`define W_RMT 5
`define W_RECEIVE_IRQ_ENABLE 6
`define W_TRANSMIT_IRQ_ENABLE 7
`define W_USE_MASK 8
`define W_DIR 9
`define W_DMSK 10
`define W_MSK_HI 21
`define W_MSK_LO 11
`define W_ID_HI 32
`define W_ID_LO 22
`define WORD_W 33

`endif

// [core/obj_ram.v]
module obj_ram #(
  parameter DEPTH = 32,
  parameter AW = 5,
  parameter DW = 33
) (
  // Clock
  input wire clock,
  // Access
  input wire [AW-1:0] addr,
  input wire we,
  input wire [DW-1:0] wdata,
  output reg [DW-1:0] rdata
);

// ----------------------------------------
// Storage with registered read
// ----------------------------------------
reg [DW-1:0] mem [0:DEPTH-1];

always @(posedge clock) begin
  if (we) begin
    mem[addr] <= wdata;
  end
  rdata <= mem[addr];
end

endmodule // obj_ram

// [core/accept_filter.v]
`include "can_msg_ctrl_map.vh"
module accept_filter #(
  parameter IDW = 11
) (
  // Object setup
  input wire [IDW-1:0] objId,
  input wire [IDW-1:0] objMask,
  input wire useMask,
  input wire dirMask,
  input wire objDir,
  // Incoming frame
  input wire [IDW-1:0] frameId,
  input wire remote,
  // Result
  output wire match
);

// ----------------------------------------
// Identifier and direction compare
// ----------------------------------------
wire [IDW-1:0] diff;
wire [IDW-1:0] careBits;
wire dirOk;

assign diff = objId ^ frameId;
assign careBits = useMask ? objMask : {IDW{1'b1}};
assign dirOk = (useMask && !dirMask) || (objDir == remote);
assign match = ((diff & careBits) == {IDW{1'b0}}) && dirOk;

endmodule // accept_filter

// [core/can_msg_object_control.v]
// Chosen here: the Avalon-MM register port.
`include "can_msg_ctrl_map.vh"
module can_msg_object_control #(
  parameter OBJECTS = 32,
  parameter OBJ_W = 5
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Avalon-MM slave
  input wire [31:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output wire waitrequest,
  // Message handler events
  input wire evValid,
  output wire evReady,
  input wire [1:0] evKind,
  input wire [10:0] evId,
  input wire [3:0] evLength,
  input wire [OBJ_W-1:0] evObj,
  // Store and transmit hints
  output reg storeStrobe,
  output reg [OBJ_W-1:0] storeObj,
  output reg [3:0] storeBytes,
  output reg txAvail,
  output reg [OBJ_W-1:0] txObj,
  // Interrupt
  output reg [OBJ_W:0] irqId,
  output wire irq
);

localparam S_IDLE = 3'h0;
localparam S_CPURD = 3'h1;
localparam S_SCAN = 3'h2;
localparam S_CHECK = 3'h3;
localparam S_TXUPD = 3'h4;

// ----------------------------------------
// State
// ----------------------------------------
reg [2:0] state_r;
reg [15:0] ctrlIf_r [0:1];
reg [15:0] arbIf_r [0:1];
reg [15:0] maskIf_r [0:1];
reg [OBJ_W-1:0] cmdObj_r;
reg cmdPend_r;
reg cmdIf_r;
reg cmdWr_r;
reg [OBJECTS-1:0] validVec_r;
reg [OBJECTS-1:0] txrqVec_r;
reg [OBJECTS-1:0] ipndVec_r;
reg [`ST_W-1:0] status_r;
reg [`ST_W-1:0] irqMask_r;
reg [OBJ_W-1:0] scan_r;
reg [1:0] evKind_r;
reg [10:0] evId_r;
reg [3:0] evLen_r;
reg [OBJ_W-1:0] evObj_r;
reg ack_r;
reg [31:0] rdNxt;
reg [`ST_W-1:0] stSet;
reg [OBJ_W-1:0] ramAddr;
reg ramWe;
reg [`WORD_W-1:0] ramWdata;
reg [OBJ_W-1:0] txNxt;
reg txAvailNxt;
reg [OBJ_W:0] irqIdNxt;
wire [`WORD_W-1:0] ramRdata;
wire match;
wire isIfReg;
wire ifSel;
wire accept;
wire [15:0] ctrlView0;
wire [15:0] ctrlView1;
integer i;
integer j;

// ----------------------------------------
// Bus decode and wait states
// ----------------------------------------
assign isIfReg = (address == `A_CTRL_IF1) || (address == `A_CTRL_IF2) ||
  (address == `A_CMD_IF1) || (address == `A_CMD_IF2) ||
  (address == `A_MASK_IF1) || (address == `A_MASK_IF2) ||
  (address == `A_ARB_IF1) || (address == `A_ARB_IF2);
assign ifSel = (address == `A_CTRL_IF2) || (address == `A_CMD_IF2) ||
  (address == `A_MASK_IF2) || (address == `A_ARB_IF2);
assign waitrequest = (read || write) && !ack_r;
assign accept = (read || write) && ack_r;
assign evReady = (state_r == S_IDLE) && !cmdPend_r;
assign irq = |(status_r & irqMask_r);
assign ctrlView0 = ctrlIf_r[0] & `CTRL_WMASK;
assign ctrlView1 = ctrlIf_r[1] & `CTRL_WMASK;

always @* begin
  rdNxt = 32'h00000000;
  if (address == `A_CTRL_IF1) begin
    rdNxt[15:0] = ctrlView0;
  end else if (address == `A_CTRL_IF2) begin
    rdNxt[15:0] = ctrlView1;
  end else if (address == `A_CMD_IF1 || address == `A_CMD_IF2) begin
    rdNxt[OBJ_W-1:0] = cmdObj_r;
  end else if (address == `A_MASK_IF1) begin
    rdNxt[15:0] = maskIf_r[0];
  end else if (address == `A_MASK_IF2) begin
    rdNxt[15:0] = maskIf_r[1];
  end else if (address == `A_ARB_IF1) begin
    rdNxt[15:0] = arbIf_r[0];
  end else if (address == `A_ARB_IF2) begin
    rdNxt[15:0] = arbIf_r[1];
  end else if (address == `A_STATUS) begin
    rdNxt[`ST_W-1:0] = status_r;
  end else if (address == `A_IRQMASK) begin
    rdNxt[`ST_W-1:0] = irqMask_r;
  end else if (address == `A_IRQID) begin
    rdNxt[OBJ_W:0] = irqId;
  end
end

always @(posedge clock or posedge rst) begin
  if (rst) begin
    ack_r <= 1'b0;
    readdata <= 32'h00000000;
  end else begin
    ack_r <= (read || write) && !ack_r && !(cmdPend_r && isIfReg);
    if (read && !ack_r) begin
      readdata <= rdNxt;
    end
  end
end

// ----------------------------------------
// Object memory and filter
// ----------------------------------------
obj_ram #(
  .DEPTH(OBJECTS),
  .AW(OBJ_W),
  .DW(`WORD_W)
) u_ram (
  .clock(clock),
  .addr(ramAddr),
  .we(ramWe),
  .wdata(ramWdata),
  .rdata(ramRdata)
);

accept_filter #(
  .IDW(11)
) u_filter (
  .objId(ramRdata[`W_ID_HI:`W_ID_LO]),
  .objMask(ramRdata[`W_MSK_HI:`W_MSK_LO]),
  .useMask(ramRdata[`W_USE_MASK]),
  .dirMask(ramRdata[`W_DMSK]),
  .objDir(ramRdata[`W_DIR]),
  .frameId(evId_r),
  .remote(evKind_r == `EV_RXRMT),
  .match(match)
);

always @* begin
  ramAddr = scan_r;
  ramWe = 1'b0;
  ramWdata = ramRdata;
  if (state_r == S_IDLE) begin
    ramAddr = cmdPend_r ? cmdObj_r : evObj;
    ramWe = cmdPend_r && cmdWr_r;
    ramWdata[`W_LEN_HI:`W_LEN_LO] = ctrlIf_r[cmdIf_r][`LEN_HI:`LEN_LO];
    ramWdata[`W_EOB] = ctrlIf_r[cmdIf_r][`EOB_BIT];
    ramWdata[`W_RMT] = ctrlIf_r[cmdIf_r][`RMT_BIT];
    ramWdata[`W_RECEIVE_IRQ_ENABLE] = ctrlIf_r[cmdIf_r][`RECEIVE_IRQ_ENABLE_BIT];
    ramWdata[`W_TRANSMIT_IRQ_ENABLE] = ctrlIf_r[cmdIf_r][`TRANSMIT_IRQ_ENABLE_BIT];
    ramWdata[`W_USE_MASK] = ctrlIf_r[cmdIf_r][`USE_MASK_BIT];
    ramWdata[`W_DIR] = arbIf_r[cmdIf_r][`ARB_DIR_BIT];
    ramWdata[`W_DMSK] = maskIf_r[cmdIf_r][`MSK_DIR_BIT];
    ramWdata[`W_MSK_HI:`W_MSK_LO] = maskIf_r[cmdIf_r][`ID_HI:0];
    ramWdata[`W_ID_HI:`W_ID_LO] = arbIf_r[cmdIf_r][`ID_HI:0];
  end else if (state_r == S_CHECK) begin
    ramAddr = scan_r;
    ramWe = validVec_r[scan_r] && match && (evKind_r == `EV_RXDATA);
    ramWdata[`W_LEN_HI:`W_LEN_LO] = evLen_r;
  end
end

// ----------------------------------------
// Transmit pick and interrupt identifier
// ----------------------------------------
always @* begin
  txNxt = {OBJ_W{1'b0}};
  txAvailNxt = 1'b0;
  irqIdNxt = {(OBJ_W+1){1'b0}};
  for (i = OBJECTS - 1; i >= 0; i = i - 1) begin
    if (txrqVec_r[i] && validVec_r[i]) begin
      txNxt = i[OBJ_W-1:0];
      txAvailNxt = 1'b1;
    end
    if (ipndVec_r[i]) begin
      irqIdNxt = i[OBJ_W:0] + {{OBJ_W{1'b0}}, 1'b1};
    end
  end
end

always @(posedge clock or posedge rst) begin
  if (rst) begin
    txObj <= {OBJ_W{1'b0}};
    txAvail <= 1'b0;
    irqId <= {(OBJ_W+1){1'b0}};
  end else begin
    txObj <= txNxt;
    txAvail <= txAvailNxt;
    irqId <= irqIdNxt;
  end
end

// ----------------------------------------
// Status, mask and interface registers
// ----------------------------------------
always @(posedge clock or posedge rst) begin
  if (rst) begin
    status_r <= {`ST_W{1'b0}};
    irqMask_r <= {`ST_W{1'b0}};
  end else begin
    if (accept && write && address == `A_STATUS) begin
      status_r <= (status_r & ~writedata[`ST_W-1:0]) | stSet;
    end else begin
      status_r <= status_r | stSet;
    end
    if (accept && write && address == `A_IRQMASK) begin
      irqMask_r <= writedata[`ST_W-1:0];
    end
  end
end

always @(posedge clock or posedge rst) begin
  if (rst) begin
    for (j = 0; j < 2; j = j + 1) begin
      ctrlIf_r[j] <= `CTRL_RST;
      arbIf_r[j] <= 16'h0000;
      maskIf_r[j] <= 16'h0000;
    end
    cmdObj_r <= {OBJ_W{1'b0}};
    cmdPend_r <= 1'b0;
    cmdIf_r <= 1'b0;
    cmdWr_r <= 1'b0;
  end else begin
    if (accept && write && isIfReg) begin
      if (address == `A_CTRL_IF1 || address == `A_CTRL_IF2) begin
        ctrlIf_r[ifSel] <= writedata[15:0] & `CTRL_WMASK;
      end else if (address == `A_ARB_IF1 || address == `A_ARB_IF2) begin
        arbIf_r[ifSel] <= writedata[15:0];
      end else if (address == `A_MASK_IF1 || address == `A_MASK_IF2) begin
        maskIf_r[ifSel] <= writedata[15:0];
      end else begin
        cmdObj_r <= writedata[OBJ_W-1:0];
        cmdWr_r <= writedata[`CMD_WR_BIT];
        cmdIf_r <= ifSel;
        cmdPend_r <= 1'b1;
      end
    end else if (state_r == S_IDLE && cmdPend_r && cmdWr_r) begin
      cmdPend_r <= 1'b0;
    end else if (state_r == S_CPURD) begin
      ctrlIf_r[cmdIf_r][`LEN_HI:`LEN_LO] <= ramRdata[`W_LEN_HI:`W_LEN_LO];
      ctrlIf_r[cmdIf_r][`EOB_BIT] <= ramRdata[`W_EOB];
      ctrlIf_r[cmdIf_r][`TXRQ_BIT] <= txrqVec_r[cmdObj_r];
      ctrlIf_r[cmdIf_r][`RMT_BIT] <= ramRdata[`W_RMT];
      ctrlIf_r[cmdIf_r][`RECEIVE_IRQ_ENABLE_BIT] <= ramRdata[`W_RECEIVE_IRQ_ENABLE];
      ctrlIf_r[cmdIf_r][`TRANSMIT_IRQ_ENABLE_BIT] <= ramRdata[`W_TRANSMIT_IRQ_ENABLE];
      ctrlIf_r[cmdIf_r][`USE_MASK_BIT] <= ramRdata[`W_USE_MASK];
      ctrlIf_r[cmdIf_r][`IPND_BIT] <= ipndVec_r[cmdObj_r];
      arbIf_r[cmdIf_r] <= {validVec_r[cmdObj_r], 1'b0, ramRdata[`W_DIR], 2'b00,
        ramRdata[`W_ID_HI:`W_ID_LO]};
      maskIf_r[cmdIf_r] <= {1'b0, ramRdata[`W_DMSK], 3'b000,
        ramRdata[`W_MSK_HI:`W_MSK_LO]};
      cmdPend_r <= 1'b0;
    end
  end
end

// ----------------------------------------
// Message handler sequencer
// ----------------------------------------
always @* begin
  stSet = {`ST_W{1'b0}};
  if (state_r == S_CHECK && validVec_r[scan_r] && match) begin
    if (evKind_r == `EV_RXDATA) begin
      stSet[`ST_RX] = 1'b1;
    end else if (ramRdata[`W_DIR] && ramRdata[`W_RMT]) begin
      stSet[`ST_RMT] = 1'b1;
    end
  end else if (state_r == S_TXUPD && validVec_r[evObj_r]) begin
    stSet[`ST_TX] = 1'b1;
  end
end

always @(posedge clock or posedge rst) begin
  if (rst) begin
    state_r <= S_IDLE;
    scan_r <= {OBJ_W{1'b0}};
    evKind_r <= `EV_RXDATA;
    evId_r <= 11'h000;
    evLen_r <= 4'h0;
    evObj_r <= {OBJ_W{1'b0}};
    validVec_r <= {OBJECTS{1'b0}};
    txrqVec_r <= {OBJECTS{1'b0}};
    ipndVec_r <= {OBJECTS{1'b0}};
    storeStrobe <= 1'b0;
    storeObj <= {OBJ_W{1'b0}};
    storeBytes <= 4'h0;
  end else begin
    storeStrobe <= 1'b0;
    case (state_r)
      S_IDLE: begin
        if (cmdPend_r) begin
          if (cmdWr_r) begin
            validVec_r[cmdObj_r] <= arbIf_r[cmdIf_r][`ARB_VAL_BIT];
            txrqVec_r[cmdObj_r] <= ctrlIf_r[cmdIf_r][`TXRQ_BIT];
            ipndVec_r[cmdObj_r] <= ctrlIf_r[cmdIf_r][`IPND_BIT];
          end else begin
            state_r <= S_CPURD;
          end
        end else if (evValid) begin
          evKind_r <= evKind;
          evId_r <= evId;
          evLen_r <= evLength;
          evObj_r <= evObj;
          scan_r <= {OBJ_W{1'b0}};
          state_r <= (evKind == `EV_TXDONE) ? S_TXUPD : S_SCAN;
        end
      end
      S_CPURD: begin
        state_r <= S_IDLE;
      end
      S_SCAN: begin
        state_r <= S_CHECK;
      end
      S_CHECK: begin
        if (validVec_r[scan_r] && match) begin
          if (evKind_r == `EV_RXDATA) begin
            storeStrobe <= 1'b1;
            storeObj <= scan_r;
            storeBytes <= (evLen_r > `MAX_BYTES) ? `MAX_BYTES : evLen_r;
            if (ramRdata[`W_RECEIVE_IRQ_ENABLE]) begin
              ipndVec_r[scan_r] <= 1'b1;
            end
          end else if (ramRdata[`W_DIR] && ramRdata[`W_RMT]) begin
            txrqVec_r[scan_r] <= 1'b1;
          end
          state_r <= S_IDLE;
        end else if (scan_r == OBJECTS - 1) begin
          state_r <= S_IDLE;
        end else begin
          scan_r <= scan_r + {{(OBJ_W-1){1'b0}}, 1'b1};
          state_r <= S_SCAN;
        end
      end
      S_TXUPD: begin
        if (validVec_r[evObj_r]) begin
          txrqVec_r[evObj_r] <= 1'b0;
          if (ramRdata[`W_TRANSMIT_IRQ_ENABLE]) begin
            ipndVec_r[evObj_r] <= 1'b1;
          end
        end
        state_r <= S_IDLE;
      end
      default: begin
        state_r <= S_IDLE;
      end
    endcase
  end
end

endmodule // can_msg_object_control

// [verif/can_msg_object_control_sva.sv]
`include "can_msg_ctrl_map.vh"
module can_msg_object_control_chk #(
  parameter OBJECTS = 32,
  parameter OBJ_W = 5
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Bus
  input wire [31:0] address,
  input wire read,
  input wire [31:0] readdata,
  input wire waitrequest,
  // Events
  input wire evValid,
  input wire evReady,
  input wire [1:0] evKind,
  input wire [3:0] evLength,
  // Hints and interrupt
  input wire storeStrobe,
  input wire [OBJ_W-1:0] storeObj,
  input wire [3:0] storeBytes,
  input wire txAvail,
  input wire [OBJ_W-1:0] txObj,
  input wire [OBJ_W:0] irqId,
  input wire irq
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [3:0] lenSeen_r;
  reg [7:0] sinceTake_r;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ----------------
  // Take tracking
  // ----------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      lenSeen_r <= 4'h0;
      sinceTake_r <= 8'h00;
    end else if (evValid && evReady) begin
      lenSeen_r <= evLength;
      sinceTake_r <= 8'h00;
    end else if (sinceTake_r != 8'hff) begin
      sinceTake_r <= sinceTake_r + 8'h01;
    end
  end
  // ----------------
  // Properties
  // ----------------
  AST_LEN_CLAMP: assert property (
    storeStrobe |-> storeBytes == ((lenSeen_r > 4'h8) ? 4'h8 : lenSeen_r))
    else $error("stored byte count wrong");
  AST_STORE_TIME: assert property (
    storeStrobe |-> sinceTake_r == 2 * storeObj + 2) else $error("store at wrong cycle");
  AST_STORE_PULSE: assert property (
    storeStrobe |=> !storeStrobe) else $error("store strobe too long");
  AST_BUSY: assert property (
    evValid && evReady |=> !evReady) else $error("event taken while busy");
  AST_NONDATA_NO_STORE: assert property (
    evValid && evReady && evKind != `EV_RXDATA |=> !storeStrobe [*4])
    else $error("store after non data event");
  AST_RESERVED_ZERO: assert property (
    read && !waitrequest && (address == `A_CTRL_IF1 || address == `A_CTRL_IF2)
      |-> readdata[6:4] == 3'h0 && readdata[31:14] == 18'h0)
    else $error("reserved bits not zero");
  AST_IRQ_RANGE: assert property (
    irqId <= OBJECTS) else $error("irq id out of range");
  AST_TX_RANGE: assert property (
    txAvail |-> txObj < OBJECTS) else $error("tx object out of range");
  AST_RESET_CLEAR: assert property (
    $fell(rst) |-> !txAvail && irqId == 0 && !irq && !storeStrobe)
    else $error("outputs not clear after reset");
endmodule // can_msg_object_control_chk

bind can_msg_object_control can_msg_object_control_chk #(.OBJECTS(OBJECTS), .OBJ_W(OBJ_W)) i_chk (
  .clock(clock), .rst(rst), .address(address), .read(read), .readdata(readdata),
  .waitrequest(waitrequest), .evValid(evValid), .evReady(evReady), .evKind(evKind),
  .evLength(evLength), .storeStrobe(storeStrobe), .storeObj(storeObj),
  .storeBytes(storeBytes), .txAvail(txAvail), .txObj(txObj), .irqId(irqId), .irq(irq));

// [verif/msg_handler_model.sv]
module msg_handler_model #(
  parameter OBJ_W = 5
) (
  // Clock
  input wire clock,
  // Event request
  output logic evValid,
  input wire evReady,
  output logic [1:0] evKind,
  output logic [10:0] evId,
  output logic [3:0] evLength,
  output logic [OBJ_W-1:0] evObj
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    evValid = 1'b0;
    evKind = 2'h3;
    evId = 11'h555;
    evLength = 4'ha;
    evObj = '1;
  end
  // ----------------
  // Event sender
  // ----------------
  task automatic send(input logic [1:0] kind, input logic [10:0] id, input logic [3:0] len,
      input logic [OBJ_W-1:0] obj, input int gap);
    repeat (gap + 1) @(posedge clock);
    evKind <= kind;
    evId <= id;
    evLength <= len;
    evObj <= obj;
    evValid <= 1'b1;
    do @(posedge clock); while (evReady !== 1'b1);
    evValid <= 1'b0;
    evKind <= ~kind;
    evId <= ~id;
    evLength <= ~len;
    evObj <= ~obj;
  endtask
endmodule // msg_handler_model

// [verif/tb_can_msg_object_control.sv]
`include "can_msg_ctrl_map.vh"
module tb_can_msg_object_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OBJ_W = 3;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [31:0] address = 32'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] rd;
  wire [31:0] readdata;
  wire waitrequest, evValid, evReady, storeStrobe, txAvail, irq;
  wire [1:0] evKind;
  wire [10:0] evId;
  wire [3:0] evLength, storeBytes;
  wire [OBJ_W-1:0] evObj, storeObj, txObj;
  wire [OBJ_W:0] irqId;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #5 clock = ~clock;
  can_msg_object_control #(.OBJECTS(8), .OBJ_W(OBJ_W)) i_dut (
    .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .evValid(evValid), .evReady(evReady), .evKind(evKind), .evId(evId),
    .evLength(evLength), .evObj(evObj), .storeStrobe(storeStrobe), .storeObj(storeObj),
    .storeBytes(storeBytes), .txAvail(txAvail), .txObj(txObj), .irqId(irqId), .irq(irq));
  msg_handler_model #(.OBJ_W(OBJ_W)) i_hdl (
    .clock(clock), .evValid(evValid), .evReady(evReady), .evKind(evKind), .evId(evId),
    .evLength(evLength), .evObj(evObj));
  // ----------------
  // Tasks
  // ----------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do @(posedge clock); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic cfg(input logic [31:0] off, input logic [31:0] obj, input logic [31:0] arb,
      input logic [31:0] ctrl, input logic [31:0] msk);
    bus(1'b1, `A_MASK_IF1 + off, msk);
    bus(1'b1, `A_ARB_IF1 + off, arb);
    bus(1'b1, `A_CTRL_IF1 + off, ctrl);
    bus(1'b1, `A_CMD_IF1 + off, obj | 32'h80);
  endtask
  task automatic fetch(input logic [31:0] off, input logic [31:0] obj, input logic [31:0] exp);
    bus(1'b1, `A_CMD_IF1 + off, obj);
    bus(1'b0, `A_CTRL_IF1 + off, 32'h0);
    chk(rd, exp);
  endtask
  task automatic expect_store(input logic hit, input logic [31:0] obj, input logic [31:0] n);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 60 && !seen; i++) begin
      @(posedge clock);
      seen = (storeStrobe === 1'b1);
    end
    chk(32'(seen), 32'(hit));
    if (hit) begin
      chk(32'(storeObj), obj);
      chk(32'(storeBytes), n);
    end
  endtask
  task automatic settle();
    repeat (40) @(posedge clock);
  endtask
  // ----------------
  // Sequence
  // ----------------
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    bus(1'b0, `A_CTRL_IF1, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, `A_CTRL_IF2, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 32'h40050200, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, `A_CTRL_IF1, 32'hffff);
    bus(1'b0, `A_CTRL_IF1, 32'h0);
    chk(rd, 32'h3f8f);
    cfg(32'h0, 0, 32'h8123, 32'h0480, 32'h0);
    cfg(32'h0, 1, 32'ha2aa, 32'h0a88, 32'h0);
    cfg(32'h60, 2, 32'h8100, 32'h1000, 32'h0700);
    for (int i = 0; i < 16; i++) begin
      i_hdl.send(`EV_RXDATA, 11'h100 + 11'(i), 4'(i), '0, i % 3);
      expect_store(1'b1, 2, (i > 8) ? 8 : i);
    end
    fetch(32'h60, 2, 32'h100f);
    chk(32'(irq), 32'h0);
    bus(1'b1, `A_IRQMASK, 32'h1);
    bus(1'b0, `A_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h1);
    chk(32'(irq), 32'h1);
    bus(1'b1, `A_STATUS, 32'h7);
    bus(1'b0, `A_STATUS, 32'h0);
    chk(rd, 32'h0);
    chk(32'(irq), 32'h0);
    i_hdl.send(`EV_RXDATA, 11'h123, 4'h3, '0, 2);
    expect_store(1'b1, 0, 3);
    fetch(32'h0, 0, 32'h2483);
    bus(1'b0, `A_IRQID, 32'h0);
    chk(rd, 32'h1);
    i_hdl.send(`EV_RXRMT, 11'h2aa, 4'h0, '0, 0);
    settle();
    chk(32'(txAvail), 32'h1);
    chk(32'(txObj), 32'h1);
    i_hdl.send(`EV_TXDONE, 11'h0, 4'h0, 3'h1, 1);
    settle();
    chk(32'(txAvail), 32'h0);
    fetch(32'h0, 1, 32'h2a88);
    cfg(32'h0, 0, 32'h8123, 32'h1680, 32'h07ff);
    settle();
    chk(32'(irqId), 32'h2);
    i_hdl.send(`EV_RXRMT, 11'h123, 4'h0, '0, 0);
    settle();
    chk(32'(txAvail), 32'h0);
    cfg(32'h60, 1, 32'ha2aa, 32'h0888, 32'h0);
    settle();
    chk(32'(irqId), 32'h0);
    i_hdl.send(`EV_RXRMT, 11'h2aa, 4'h0, '0, 3);
    settle();
    chk(32'(txAvail), 32'h0);
    cfg(32'h0, 0, 32'h0123, 32'h0480, 32'h0);
    i_hdl.send(`EV_RXDATA, 11'h123, 4'h2, '0, 0);
    expect_store(1'b1, 2, 2);
    final_report();
  end
endmodule // tb_can_msg_object_control
